// File: hw/brs_sync_status.sv
// per-channel receive sync state machine and character status tagger
//
// Behaviour
// R1 - each channel has its own sync machine, running only while bonding is selected
// R2 - bonding off (modes 0, 1): machine idle, status straight from decoding
// R3 - machine tracks loss and recovery of framing and helps bonding control
// R4 - Type A and Type B machine variants; selected style decides which runs
// R5 - Type A: four states, only in-sync gives several codes; here resync also passes decoded codes
// R6 - Type B: four states, some give one code, others several
// R7 - code 000 marks a valid data character
// R8 - code 001 marks a valid special character, not framing nor violation
// R9 - Type A code 010 marks elasticity buffer under or overrun
// R10 - Type B code 010 marks channel lock, on last character before aligned data
// R11 - code 011 marks a framing character, its decoded value on the bus
// R12 - code 100 marks a codeword violation, bus carries replacement character
// R13 - code 101 marks loss of sync or bonded misalignment
// R14 - Type B also uses code 101 for elasticity buffer errors
// R15 - independent channels use code 101 for receive pll out of lock
// R16 - code 110 marks running disparity error
// R17 - code 111 marks the resync state, bus shows the framing character
// R18 - low bit of receive mode select picks Type A or Type B
// R19 - overlapping conditions settle by priority, bad disparity is not data
// R20 - four framing characters in a row are needed to gain sync
// R21 - sync dropped on buffer error, pll unlock, four decode errors, or margin 4
// R22 - smallest priority number wins when several conditions hold
// R23 - status is registered together with its character
`timescale 1ns/1ps
`default_nettype none
module brs_sync_status (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [1:0] receive_mode_select,
	input wire logic framing_char_select,
	input wire logic pll_unlock,
	input wire logic char_valid,
	input wire logic [7:0] char_data,
	input wire logic char_special,
	input wire logic char_k28_5,
	input wire logic char_comma,
	input wire logic code_violation,
	input wire logic disparity_error,
	input wire logic elastic_error,
	input wire logic bond_inhibit,
	input wire logic deskew_expired,
	input wire logic bond_locked,
	input wire logic host_ready,
	output logic char_ready,
	output logic [7:0] receive_data_bus,
	output logic [2:0] receive_char_status,
	output logic receive_valid,
	output var brs_pkg::brs_sync_t sync_state
);
	logic [1:0] mode_meta_reg, mode_meta_next, mode_sync_reg, mode_sync_next;
	logic pll_meta_reg, pll_meta_next, pll_sync_reg, pll_sync_next;
	brs_pkg::brs_sync_t state_reg, state_next;
	logic [2:0] fram_run_reg, fram_run_next;
	logic [2:0] err_run_reg, err_run_next;
	logic [2:0] margin_reg, margin_next;
	logic [7:0] data_reg, data_next;
	logic [2:0] status_reg, status_next;
	logic valid_reg, valid_next;
	logic bond_on, type_b, framing_hit, dec_err, hard_err;
	logic wr_fire, lock_now, a_align;
	logic [2:0] char_code, stat_code;
	logic [brs_pkg::CHAR_W-1:0] fifo_data;
	logic fifo_valid, fifo_take;

	brs_char_if #(.W(brs_pkg::CHAR_W)) ch_if ();

	// two-stage synchronisers for the strap-like mode pins and the pll flag
	always_comb begin
		mode_meta_next = receive_mode_select;
		mode_sync_next = mode_meta_reg;
		pll_meta_next = pll_unlock;
		pll_sync_next = pll_meta_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode_meta_reg <= brs_pkg::MODE_RESET;
			mode_sync_reg <= brs_pkg::MODE_RESET;
			pll_meta_reg <= brs_pkg::PLL_LOST_RESET;
			pll_sync_reg <= brs_pkg::PLL_LOST_RESET;
		end else begin
			mode_meta_reg <= mode_meta_next;
			mode_sync_reg <= mode_sync_next;
			pll_meta_reg <= pll_meta_next;
			pll_sync_reg <= pll_sync_next;
		end
	end

	// R1 bonding enable bit
	assign bond_on = mode_sync_reg[brs_pkg::MODE_BOND_BIT];
	// R18 reporting style bit
	assign type_b = mode_sync_reg[brs_pkg::MODE_TYPE_BIT];

	// framing pattern follows the select: any comma or the full K28.5 only
	assign framing_hit = framing_char_select ? char_comma : char_k28_5;
	assign dec_err = code_violation || disparity_error;
	assign hard_err = elastic_error || pll_sync_reg;
	assign wr_fire = char_valid && ch_if.ready;

	// R10 Type B lock on the last framing character before aligned data
	assign lock_now = type_b && framing_hit && bond_locked && !dec_err;
	// R5 Type A leaves resync on the first aligned non-framing character
	assign a_align = !type_b && bond_locked && !framing_hit && !dec_err;

	brs_status_enc u_enc (
		.pll_lost(pll_sync_reg),
		.elastic_error(elastic_error),
		.code_violation(code_violation),
		.framing(framing_hit),
		.disparity_error(disparity_error),
		.special(char_special),
		.type_b(type_b),
		.code(char_code)
	);

	// sync machine; counters only step on accepted characters, and bonding off or pll loss clears them
	always_comb begin
		state_next = state_reg;
		fram_run_next = fram_run_reg;
		err_run_next = err_run_reg;
		margin_next = margin_reg;
		// R2 machine held idle without bonding
		if (!bond_on) begin
			state_next = brs_pkg::state_no_sync;
			fram_run_next = brs_pkg::RUN_RESET;
			err_run_next = brs_pkg::RUN_RESET;
			margin_next = brs_pkg::RUN_RESET;
		// R21 pll loss drops sync even between characters
		end else if (pll_sync_reg) begin
			state_next = brs_pkg::state_no_sync;
			fram_run_next = brs_pkg::RUN_RESET;
			err_run_next = brs_pkg::RUN_RESET;
			margin_next = brs_pkg::RUN_RESET;
		end else if (wr_fire) begin
			// run counters saturate at their limits
			if (!framing_hit) begin
				fram_run_next = brs_pkg::RUN_RESET;
			end else if (fram_run_reg != brs_pkg::FRAMING_RUN) begin
				fram_run_next = fram_run_reg + 1'b1;
			end
			if (!dec_err) begin
				err_run_next = brs_pkg::RUN_RESET;
			end else if (err_run_reg != brs_pkg::DEC_ERR_RUN) begin
				err_run_next = err_run_reg + 1'b1;
			end
			// invalid minus valid, floored at zero
			if (dec_err && margin_reg != brs_pkg::INV_MARGIN) begin
				margin_next = margin_reg + 1'b1;
			end else if (!dec_err && margin_reg != '0) begin
				margin_next = margin_reg - 1'b1;
			end
			// R3 framing loss and recovery
			unique case (state_reg)
				brs_pkg::state_no_sync: begin
					// R20 four framing characters in a row
					if (!elastic_error && framing_hit && fram_run_reg == brs_pkg::FRAMING_RUN - 3'h1) begin
						state_next = brs_pkg::state_resync;
					end
				end
				brs_pkg::state_resync: begin
					// any decode error while resyncing restarts the search
					if (elastic_error || dec_err) begin
						state_next = brs_pkg::state_no_sync;
					end else if (deskew_expired && !bond_inhibit) begin
						state_next = brs_pkg::state_bond_failed;
					// R4 exit condition depends on style
					end else if (lock_now || a_align) begin
						state_next = brs_pkg::state_in_sync;
					end
				end
				brs_pkg::state_bond_failed: begin
					if (elastic_error || dec_err) begin
						state_next = brs_pkg::state_no_sync;
					end else if (framing_hit && fram_run_reg == brs_pkg::FRAMING_RUN - 3'h1) begin
						state_next = brs_pkg::state_resync;
					end
				end
				brs_pkg::state_in_sync: begin
					// R21 drop conditions while in sync
					if (elastic_error || err_run_next == brs_pkg::DEC_ERR_RUN ||
						margin_next == brs_pkg::INV_MARGIN) begin
						state_next = brs_pkg::state_no_sync;
					end
				end
			endcase
			if (state_next != state_reg) begin
				margin_next = brs_pkg::RUN_RESET;
				err_run_next = brs_pkg::RUN_RESET;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= brs_pkg::state_no_sync;
			fram_run_reg <= brs_pkg::RUN_RESET;
			err_run_reg <= brs_pkg::RUN_RESET;
			margin_reg <= brs_pkg::RUN_RESET;
		end else begin
			state_reg <= state_next;
			fram_run_reg <= fram_run_next;
			err_run_reg <= err_run_next;
			margin_reg <= margin_next;
		end
	end

	// status per state; no-sync and bond-failed give the loss code, resync and in-sync pass several codes
	always_comb begin
		stat_code = char_code;
		if (bond_on) begin
			unique case (state_reg)
				// R13 not framed or bonding lost
				brs_pkg::state_no_sync, brs_pkg::state_bond_failed: begin
					stat_code = brs_pkg::ST_LOSS;
				end
				brs_pkg::state_resync: begin
					// R6 Type B resync gives loss on hard errors, else lock or resync
					if (hard_err) begin
						stat_code = char_code;
					end else if (lock_now) begin
						stat_code = brs_pkg::ST_LOCK;
					end else if (!a_align) begin
						// R17 resync code with framing char on bus
						stat_code = brs_pkg::ST_RESYNC;
					end
				end
				brs_pkg::state_in_sync: begin
					stat_code = char_code;
				end
			endcase
		end
	end

	// R23 status and character travel as one word
	assign ch_if.data = {stat_code, char_data};
	assign ch_if.valid = char_valid;
	assign char_ready = ch_if.ready;

	// buffer absorbs host stalls; its ready is the decoder's back-pressure
	brs_char_fifo #(
		.WIDTH(brs_pkg::CHAR_W),
		.DEPTH(brs_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(ref_clk),
		.rst(sys_rst),
		.wr(ch_if.snk),
		.rd_data(fifo_data),
		.rd_valid(fifo_valid),
		.rd_ready(fifo_take)
	);

	// output register reloads whenever empty or the host takes the word
	assign fifo_take = !valid_reg || host_ready;

	always_comb begin
		data_next = data_reg;
		status_next = status_reg;
		valid_next = valid_reg;
		if (fifo_take) begin
			valid_next = fifo_valid;
			if (fifo_valid) begin
				data_next = fifo_data[brs_pkg::DATA_W-1:0];
				status_next = fifo_data[brs_pkg::CHAR_W-1:brs_pkg::DATA_W];
			end
		end
	end

	// R23 status and data share one edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			data_reg <= brs_pkg::DATA_RESET;
			status_reg <= brs_pkg::STAT_RESET;
			valid_reg <= 1'b0;
		end else begin
			data_reg <= data_next;
			status_reg <= status_next;
			valid_reg <= valid_next;
		end
	end

	assign receive_data_bus = data_reg;
	assign receive_char_status = status_reg;
	assign receive_valid = valid_reg;
	assign sync_state = state_reg;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	// R2 idle machine without bonding
	bond_off_idle_a: assert property (!bond_on |=> state_reg == brs_pkg::state_no_sync) // R2
		else $error("sync machine active with bonding off");

	// R13 loss code outside sync
	nosync_code_a: assert property (wr_fire && bond_on && state_reg != brs_pkg::state_in_sync && // R13
		state_reg != brs_pkg::state_resync |-> ch_if.data[10:8] == brs_pkg::ST_LOSS)
		else $error("unsynced character not tagged loss of sync");

	// R17 resync code
	resync_code_a: assert property (wr_fire && bond_on && state_reg == brs_pkg::state_resync && // R17
		!hard_err && !lock_now && !a_align |-> ch_if.data[10:8] == brs_pkg::ST_RESYNC)
		else $error("resync character not tagged resync");

	// R10 lock then in sync
	lock_code_a: assert property (wr_fire && bond_on && type_b && !pll_sync_reg && !elastic_error && // R10
		!(deskew_expired && !bond_inhibit) && state_reg == brs_pkg::state_resync && lock_now
		|-> ch_if.data[10:8] == brs_pkg::ST_LOCK ##1 state_reg == brs_pkg::state_in_sync)
		else $error("channel lock not reported or not followed by sync");

	// R15 pll unlock urgent
	pll_priority_a: assert property (wr_fire && pll_sync_reg |-> ch_if.data[10:8] == brs_pkg::ST_LOSS) // R15
		else $error("pll loss not reported first");

	// R19 violation beats disparity
	viol_over_disp_a: assert property (wr_fire && !bond_on && !hard_err && code_violation && // R19
		disparity_error |-> ch_if.data[10:8] == brs_pkg::ST_VIOLATION)
		else $error("violation lost to a lower priority code");

	// R9 elastic code style
	elastic_style_a: assert property (wr_fire && !bond_on && !pll_sync_reg && elastic_error // R9
		|-> ch_if.data[10:8] == (type_b ? brs_pkg::ST_LOSS : brs_pkg::ST_ELASTIC))
		else $error("elasticity error reported in wrong style");

	// R20 fourth framing gains resync
	four_framing_a: assert property (wr_fire && bond_on && !pll_sync_reg && !elastic_error && // R20
		state_reg == brs_pkg::state_no_sync && framing_hit && fram_run_reg == 3'h3
		|=> state_reg == brs_pkg::state_resync)
		else $error("four framing characters did not start resync");

	// R21 four decode errors drop sync
	err_run_drop_a: assert property (wr_fire && bond_on && state_reg == brs_pkg::state_in_sync && // R21
		dec_err && err_run_reg == 3'h3 |=> state_reg == brs_pkg::state_no_sync)
		else $error("four decode errors did not drop sync");

	// R23 output pairs with buffered word
	out_pair_a: assert property (fifo_take && fifo_valid |=> receive_valid && // R23
		{receive_char_status, receive_data_bus} == $past(fifo_data))
		else $error("status and data left the register apart");
endmodule : brs_sync_status
`default_nettype wire

// File: hw/brs_pkg.sv
// shared constants and types for the bonded receive sync/status block
package brs_pkg;
	localparam int DATA_W = 8;
	localparam int STAT_W = 3;
	localparam int CHAR_W = 11;
	localparam int FIFO_DEPTH = 8;

	// receive mode select bit positions
	localparam int MODE_TYPE_BIT = 0;
	localparam int MODE_BOND_BIT = 1;

	// character status codes
	localparam logic [2:0] ST_DATA = 3'h0;
	localparam logic [2:0] ST_SPECIAL = 3'h1;
	localparam logic [2:0] ST_ELASTIC = 3'h2;
	localparam logic [2:0] ST_LOCK = 3'h2;
	localparam logic [2:0] ST_FRAMING = 3'h3;
	localparam logic [2:0] ST_VIOLATION = 3'h4;
	localparam logic [2:0] ST_LOSS = 3'h5;
	localparam logic [2:0] ST_DISPARITY = 3'h6;
	localparam logic [2:0] ST_RESYNC = 3'h7;

	// run lengths for gaining and dropping sync
	localparam logic [2:0] FRAMING_RUN = 3'h4;
	localparam logic [2:0] DEC_ERR_RUN = 3'h4;
	localparam logic [2:0] INV_MARGIN = 3'h4;

	// values after reset
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic PLL_LOST_RESET = 1'h1;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [2:0] STAT_RESET = ST_LOSS;
	localparam logic [2:0] RUN_RESET = 3'h0;

	typedef enum logic [3:0] {
		state_no_sync = 4'h1,
		state_resync = 4'h2,
		state_bond_failed = 4'h4,
		state_in_sync = 4'h8
	} brs_sync_t;
endpackage : brs_pkg

// File: hw/brs_char_if.sv
// character plus status hand-off between the tagger and the buffer
`timescale 1ns/1ps
`default_nettype none
interface brs_char_if #(parameter int W = 11);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : brs_char_if
`default_nettype wire

// File: hw/brs_status_enc.sv
// priority encoder for the per-character status conditions
`timescale 1ns/1ps
`default_nettype none
module brs_status_enc (
	input wire logic pll_lost,
	input wire logic elastic_error,
	input wire logic code_violation,
	input wire logic framing,
	input wire logic disparity_error,
	input wire logic special,
	input wire logic type_b,
	output logic [2:0] code
);
	// R22 most urgent wins
	// lower priority number checked first; R19 bad disparity never reads as data
	always_comb begin
		// R15 pll out of lock
		if (pll_lost) begin
			code = brs_pkg::ST_LOSS;
		// R9 R14 elastic error style
		end else if (elastic_error) begin
			code = type_b ? brs_pkg::ST_LOSS : brs_pkg::ST_ELASTIC;
		// R12 codeword violation
		end else if (code_violation) begin
			code = brs_pkg::ST_VIOLATION;
		// R11 framing char seen
		end else if (framing) begin
			code = brs_pkg::ST_FRAMING;
		// R16 disparity error
		end else if (disparity_error) begin
			code = brs_pkg::ST_DISPARITY;
		// R8 special code
		end else if (special) begin
			code = brs_pkg::ST_SPECIAL;
		// R7 plain data
		end else begin
			code = brs_pkg::ST_DATA;
		end
	end
endmodule : brs_status_enc
`default_nettype wire

// File: hw/brs_char_fifo.sv
// flip-flop fifo holding tagged characters ahead of the output register
`timescale 1ns/1ps
`default_nettype none
module brs_char_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	brs_char_if.snk wr,
	output logic [WIDTH-1:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
	logic [DEPTH-1:0][WIDTH-1:0] mem_next;
	logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [CW-1:0] count_reg, count_next;
	logic room_reg, room_next;
	logic push, pop;

	assign push = wr.valid && room_reg;
	assign pop = rd_valid && rd_ready;
	assign wr.ready = room_reg;
	assign rd_valid = (count_reg != '0);
	assign rd_data = mem_reg[rd_ptr_reg];

	// one write port per entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		assign mem_next[i] = (push && wr_ptr_reg == AW'(i)) ? wr.data : mem_reg[i];
	end

	// pointers wrap at the last entry; ready is a flop so the source sees no glitch
	always_comb begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next = count_reg;
		if (push) begin
			wr_ptr_next = (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
		end
		if (pop) begin
			rd_ptr_next = (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
		end
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
		room_next = (count_next != FULL);
	end

	always_ff @(posedge clk) begin
		mem_reg <= mem_next;
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			room_reg <= 1'b1;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
			room_reg <= room_next;
		end
	end
endmodule : brs_char_fifo
`default_nettype wire

// File: test/brs_host_model.sv
// host side model that takes receive words with random stalls
`timescale 1ns/1ps
`default_nettype none
module brs_host_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic stall,
	input wire logic receive_valid,
	input wire logic [7:0] receive_data_bus,
	input wire logic [2:0] receive_char_status,
	output logic host_ready,
	output logic taken,
	output logic [10:0] word
);
	int seed = 55064;

	// random ready so both prompt and slow hosts are seen
	always @(posedge ref_clk) begin
		taken <= !sys_rst && receive_valid && host_ready;
		word <= {receive_char_status, receive_data_bus};
		host_ready <= !sys_rst && !stall && (($random(seed) & 32'h3) != 32'h0);
	end

	// quiet start before the first edge
	initial begin
		host_ready = 1'b0;
		taken = 1'b0;
		word = 11'h000;
	end
endmodule : brs_host_model
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the bonded receive sync and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [4:0] FD = 5'h00;
	localparam logic [4:0] FR = 5'h04;
	localparam logic [4:0] FS = 5'h01;
	localparam logic [4:0] FP = 5'h02;
	localparam logic [4:0] FV = 5'h08;
	localparam logic [4:0] FE = 5'h10;
	logic ref_clk, sys_rst, framing_char_select, pll_unlock, char_valid, char_special, char_k28_5;
	logic char_comma, code_violation, disparity_error, elastic_error, bond_inhibit, deskew_expired;
	logic bond_locked, host_ready, char_ready, receive_valid, stall, taken;
	logic [1:0] receive_mode_select;
	logic [7:0] char_data, receive_data_bus;
	logic [2:0] receive_char_status;
	logic [10:0] word;
	logic [31:0] r;
	brs_pkg::brs_sync_t sync_state;
	logic [10:0] exp_q[$];
	int fail_count = 0;
	int n_compared = 0;
	int seed = 55064;

	brs_sync_status u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .receive_mode_select(receive_mode_select),
		.framing_char_select(framing_char_select), .pll_unlock(pll_unlock), .char_valid(char_valid),
		.char_data(char_data), .char_special(char_special), .char_k28_5(char_k28_5), .char_comma(char_comma),
		.code_violation(code_violation), .disparity_error(disparity_error), .elastic_error(elastic_error),
		.bond_inhibit(bond_inhibit), .deskew_expired(deskew_expired), .bond_locked(bond_locked),
		.host_ready(host_ready), .char_ready(char_ready), .receive_data_bus(receive_data_bus),
		.receive_char_status(receive_char_status), .receive_valid(receive_valid), .sync_state(sync_state));

	brs_host_model u_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .stall(stall), .receive_valid(receive_valid),
		.receive_data_bus(receive_data_bus), .receive_char_status(receive_char_status),
		.host_ready(host_ready), .taken(taken), .word(word));

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	task automatic check(input string what, input logic [10:0] got, input logic [10:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// independent status by priority: elastic, violation, framing, disparity, special, data
	function automatic logic [2:0] exp_indep(input logic type_b, input logic [4:0] f);
		if (f[4])
			return type_b ? 3'h5 : 3'h2;
		if (f[3])
			return 3'h4;
		if (f[2])
			return 3'h3;
		if (f[1])
			return 3'h6;
		if (f[0])
			return 3'h1;
		return 3'h0;
	endfunction : exp_indep

	// offer one character; called and left at a rising edge
	task automatic snd(input logic [7:0] d, input logic [4:0] f, input logic [2:0] e);
		int n;
		n = 0;
		char_valid <= 1'b1;
		char_data <= d;
		char_special <= f[0];
		disparity_error <= f[1];
		char_comma <= f[2];
		// with the comma selected, K28.5 carries the opposite so it must be ignored; with K28.5 selected both match
		char_k28_5 <= f[2] ^ framing_char_select;
		code_violation <= f[3];
		elastic_error <= f[4];
		exp_q.push_back({e, d});
		@(negedge ref_clk);
		while (char_ready !== 1'b1 && n < 500) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
	endtask : snd

	// release the inputs and wait for every word to reach the host
	task automatic settle(input string name);
		int n;
		n = 0;
		char_valid <= 1'b0;
		char_data <= ~char_data;
		while (exp_q.size() != 0 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (2) @(posedge ref_clk);
		check("words left", 11'(exp_q.size()), 11'h000);
		$display("test %s done", name);
	endtask : settle

	task automatic set_mode(input logic [1:0] m, input logic fsel);
		receive_mode_select <= m;
		framing_char_select <= fsel;
		repeat (4) @(posedge ref_clk);
	endtask : set_mode

	// words arriving at the host are compared in order
	always @(posedge ref_clk) begin
		if (taken) begin
			// a word nobody sent can never match its own inverse
			if (exp_q.size() == 0)
				check("extra word", word, ~word);
			else
				check("status and data", word, exp_q.pop_front());
		end
	end

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// run is several hundred cycles, so this only trips on a hang
	initial begin
		#(25 * 30000);
		fail_count++;
		$display("watchdog expired");
		results();
	end

	initial begin
		{sys_rst, receive_mode_select, framing_char_select, pll_unlock, char_valid} = 6'h20;
		{char_special, char_k28_5, char_comma, code_violation, disparity_error, elastic_error} = 6'h00;
		{bond_inhibit, deskew_expired, bond_locked, stall, char_data} = 12'h000;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check("reset state", 11'(sync_state), 11'(brs_pkg::state_no_sync));
		// independent channels, both styles and both framing selections
		for (int m = 0; m < 4; m++) begin
			set_mode({1'b0, m[0]}, m[1]);
			for (int i = 0; i < 50; i++) begin
				r = $random(seed);
				snd(r[17:10], r[4:0] & r[9:5], exp_indep(m[0], r[4:0] & r[9:5]));
			end
			settle("independent");
		end
		pll_unlock <= 1'b1;
		repeat (4) @(posedge ref_clk);
		snd(8'hbc, FR, 3'h5);
		settle("pll lost");
		pll_unlock <= 1'b0;
		// bonded Type A: gain sync, a failed bond, lock, then an elastic drop
		set_mode(2'h2, 1'b0);
		snd(8'h11, FD, 3'h5);
		repeat (4) snd(8'hbc, FR, 3'h5);
		settle("type a framing run");
		check("sync state", 11'(sync_state), 11'(brs_pkg::state_resync));
		deskew_expired <= 1'b1;
		snd(8'hbc, FR, 3'h7);
		deskew_expired <= 1'b0;
		settle("deskew expired");
		check("sync state", 11'(sync_state), 11'(brs_pkg::state_bond_failed));
		snd(8'h22, FD, 3'h5);
		repeat (4) snd(8'hbc, FR, 3'h5);
		settle("rebond");
		check("sync state", 11'(sync_state), 11'(brs_pkg::state_resync));
		bond_locked <= 1'b1;
		snd(8'hbc, FR, 3'h7);
		snd(8'h45, FD, 3'h0);
		snd(8'hfe, FS, 3'h1);
		snd(8'he0, FV, 3'h4);
		snd(8'he4, FP, 3'h6);
		snd(8'hbc, FR, 3'h3);
		settle("type a in sync");
		check("sync state", 11'(sync_state), 11'(brs_pkg::state_in_sync));
		snd(8'h55, FE, 3'h2);
		snd(8'h56, FD, 3'h5);
		settle("type a elastic drop");
		check("sync state", 11'(sync_state), 11'(brs_pkg::state_no_sync));
		// regain sync, then let invalid outrun valid by four without four errors in a row
		repeat (4) snd(8'hbc, FR, 3'h5);
		snd(8'h57, FD, 3'h0);
		repeat (2) snd(8'he0, FV, 3'h4);
		snd(8'h58, FD, 3'h0);
		repeat (3) snd(8'he0, FV, 3'h4);
		settle("type a margin drop");
		check("sync state", 11'(sync_state), 11'(brs_pkg::state_no_sync));
		// bonded Type B: inhibited bond failure, lock code, decoder error drop
		bond_locked <= 1'b0;
		set_mode(2'h3, 1'b1);
		snd(8'h33, FD, 3'h5);
		repeat (4) snd(8'hbc, FR, 3'h5);
		bond_inhibit <= 1'b1;
		deskew_expired <= 1'b1;
		snd(8'hbc, FR, 3'h7);
		settle("type b inhibit");
		check("sync state", 11'(sync_state), 11'(brs_pkg::state_resync));
		{bond_inhibit, deskew_expired, bond_locked} <= 3'h1;
		snd(8'hbc, FR, 3'h2);
		snd(8'h60, FD, 3'h0);
		repeat (4) snd(8'he0, FV, 3'h4);
		snd(8'h61, FD, 3'h5);
		settle("type b decoder drop");
		check("sync state", 11'(sync_state), 11'(brs_pkg::state_no_sync));
		// stalled host: the buffer fills and refuses, then drains in order
		set_mode(2'h0, 1'b0);
		stall <= 1'b1;
		fork
			begin
				for (int i = 0; i < 12; i++)
					snd(8'(i), FD, 3'h0);
				settle("fill and drain");
			end
			begin
				repeat (40) @(posedge ref_clk);
				check("buffer full", {10'h000, char_ready}, 11'h000);
				stall <= 1'b0;
			end
		join
		results();
	end
endmodule : tb
`default_nettype wire
